// *** pkg/eltc_pkg.sv ***
// Constants and types of the encoder line trigger control.
// Assumes a single 100 MHz camera clock and an ASCII command byte stream.
package eltc_pkg;

  // ==========================================================
  // Control register fields
  localparam int          CTRL_W           = 8;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam int          ADV_EN_BIT       = 7;
  localparam int          BIDIR_BIT        = 6;
  localparam int          FOUR_EDGE_BIT    = 5;
  localparam int          HYST_HI_BIT      = 4;
  localparam int          HYST_LO_BIT      = 3;
  localparam int          SCAN_SRC_BIT     = 2;
  localparam int          DIAG_HI_BIT      = 1;
  localparam int          DIAG_LO_BIT      = 0;
  localparam logic [1:0]  DIAG_OFF         = 2'h0;
  localparam logic [1:0]  DIAG_STATES      = 2'h1;
  localparam logic [1:0]  DIAG_LCNT8       = 2'h2;
  localparam logic [1:0]  DIAG_BOTH        = 2'h3;
  localparam logic [6:0]  HYST_4           = 7'h04;
  localparam logic [6:0]  HYST_16          = 7'h10;
  localparam logic [6:0]  HYST_64          = 7'h40;

  // ==========================================================
  // Counters and divider
  localparam int          POS_W            = 16;
  localparam int          LCNT_W           = 13;
  localparam int          DIV_W            = 15;
  localparam logic [14:0] DIV_RESET        = 15'h0001;
  localparam logic [16:0] CTRL_MAX         = 17'h000FF;
  localparam logic [16:0] DIV_MAX          = 17'h07FFF;
  localparam logic [16:0] VAL_CAP          = 17'h0FFFF;

  // ==========================================================
  // Command protocol characters
  localparam logic [7:0]  CH_SET_CTRL      = 8'h59;
  localparam logic [7:0]  CH_SET_DIV       = 8'h56;
  localparam logic [7:0]  CH_INFO          = 8'h49;
  localparam logic [7:0]  CH_CR            = 8'h0D;
  localparam logic [7:0]  CH_ZERO          = 8'h30;
  localparam logic [7:0]  CH_NINE          = 8'h39;
  localparam logic [7:0]  CH_ONE           = 8'h31;
  localparam logic [16:0] INFO_CTRL_IDX    = 17'h0001D;
  localparam logic [31:0] READ_PREFIX      = 32'h5379433A;
  localparam logic [3:0]  ACK_LEN          = 4'h2;
  localparam logic [3:0]  READ_LEN         = 4'hA;

  typedef enum logic [1:0] {RSP_OK, RSP_FAIL, RSP_READ} eltc_rsp_type;

endpackage : eltc_pkg

// *** design/eltc_buf2.sv ***
// Two-entry buffer in the pixel path with valid/ready on both sides.
// Assumes both sides run on i_clk; outputs are registered.
`timescale 1ns/1ps
`default_nettype none
module eltc_buf2 (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // Filling side
  input  wire logic [15:0] i_in_data,
  input  wire logic        i_in_valid,
  output logic             o_in_ready,
  // Draining side
  output logic [15:0]      o_out_data,
  output logic             o_out_valid,
  input  wire logic        i_out_ready
);
  logic [15:0] mem_ff [2];
  logic [15:0] nxt_mem [2];
  logic        wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic [1:0]  cnt_ff, nxt_cnt;
  logic        push, pop;

  always_comb
  begin
    push    = i_in_valid && o_in_ready;
    pop     = o_out_valid && i_out_ready;
    nxt_mem = mem_ff;
    nxt_wr  = wr_ff;
    nxt_rd  = rd_ff;
    nxt_cnt = cnt_ff;
    if (push)
    begin
      nxt_mem[wr_ff] = i_in_data;
      nxt_wr         = ~wr_ff;
    end
    if (pop)
      nxt_rd = ~rd_ff;
    nxt_cnt = cnt_ff + 2'(push) - 2'(pop);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      wr_ff       <= 1'b0;
      rd_ff       <= 1'b0;
      cnt_ff      <= 2'h0;
      o_in_ready  <= 1'b0;
      o_out_valid <= 1'b0;
      o_out_data  <= 16'h0000;
      mem_ff[0]   <= 16'h0000;
      mem_ff[1]   <= 16'h0000;
    end
    else
    begin
      mem_ff      <= nxt_mem;
      wr_ff       <= nxt_wr;
      rd_ff       <= nxt_rd;
      cnt_ff      <= nxt_cnt;
      o_in_ready  <= nxt_cnt != 2'h2;
      o_out_valid <= nxt_cnt != 2'h0;
      o_out_data  <= nxt_mem[nxt_rd];
    end
  end
endmodule // eltc_buf2
`default_nettype wire

// *** design/eltc_divider.sv ***
// Trigger divider: one line start per programmed number of triggers.
// Assumes one-cycle trigger pulses on i_clk; ratio zero acts as one.
`timescale 1ns/1ps
`default_nettype none
module eltc_divider
  import eltc_pkg::*;
(
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  // Trigger in, ratio, line start out
  input  wire logic             i_trig,
  input  wire logic [DIV_W-1:0] i_ratio,
  output logic                  o_pulse
);
  logic [DIV_W-1:0] cnt_ff, nxt_cnt;
  logic             nxt_pulse;

  always_comb
  begin
    nxt_cnt   = cnt_ff;
    nxt_pulse = 1'b0;
    if (i_trig)
    begin
      if (cnt_ff + 15'h0001 >= i_ratio)
      begin
        nxt_cnt   = '0;
        nxt_pulse = 1'b1;
      end
      else
        nxt_cnt = cnt_ff + 15'h0001;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      cnt_ff  <= '0;
      o_pulse <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      o_pulse <= nxt_pulse;
    end
  end
endmodule // eltc_divider
`default_nettype wire

// *** design/eltc_top.sv ***
// Encoder line trigger control: quadrature triggers, divider, diag pixels.
// Assumes sync pins are asynchronous and command/pixel streams are on i_clk.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Advanced enable clear: trigger on input A rising edge, bits 3..6 ignored.
// - Bidirectional bit clear: only up motion triggers; set: both directions.
// - Direction decoded from A and B; wrong-direction pulses dropped.
// - Four-edge bit selects one trigger per period or per quadrature edge.
// - Hysteresis field: off, 4, 16 or 64 counts.
// - Source bit clear: scan start and line sync both from input A.
// - Source bit set: scan start from input B, line sync from A.
// - Diag field 00: first two pixels pass intensity unchanged.
// - Diag 01: pixel one low byte holds frame, B, A states, zeros below.
// - Diag 10: pixel one low byte holds line counter low eight bits.
// - Diag 11: input states plus 13-bit line counter over both pixels.
// - Pixel one bits 4..0 carry counter 12..8; pixel two counter 7..0.
// - Trigger pulses pass through the trigger divider before line start.
// - Divider ratio 1 to 32767 set by serial command.
// - Control written as decimal 0..255; answer 0 success, 1 failure.
// - Read returns control value as fixed prefix plus five decimal digits.
module eltc_top
  import eltc_pkg::*;
(
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_sys_rst,
  // Sync pins
  input  wire logic               i_line_sync_a,
  input  wire logic               i_line_sync_b,
  input  wire logic               i_frame_sync,
  input  wire logic               i_external_scan_start_mode,
  // Command stream in
  input  wire logic [7:0]         i_cmd_byte,
  input  wire logic               i_cmd_valid,
  output logic                    o_cmd_ready,
  // Answer stream out
  output logic [7:0]              o_rsp_byte,
  output logic                    o_rsp_valid,
  input  wire logic               i_rsp_ready,
  // Pixel stream in
  input  wire logic [15:0]        i_pix_data,
  input  wire logic               i_pix_first,
  input  wire logic               i_pix_valid,
  output logic                    o_pix_ready,
  // Pixel stream out
  output logic [15:0]             o_pix_data,
  output logic                    o_pix_valid,
  input  wire logic               i_pix_ready,
  // Line timing and state
  output logic                    o_line_start,
  output logic                    o_external_scan_start,
  output logic [CTRL_W-1:0]       o_trigger_control,
  output logic signed [POS_W-1:0] o_position
);
  // ==========================================================
  // Helpers
  function automatic logic [1:0] quad_step(input logic [1:0] p, input logic [1:0] c);
    // {B,A}; returns 01 up, 10 down, 00 none or illegal
    unique case ({p, c})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: quad_step = 2'b01;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: quad_step = 2'b10;
      default:                            quad_step = 2'b00;
    endcase
  endfunction

  function automatic logic [6:0] hyst_span(input logic [1:0] sel);
    unique case (sel)
      2'h0: hyst_span = 7'h00;
      2'h1: hyst_span = HYST_4;
      2'h2: hyst_span = HYST_16;
      2'h3: hyst_span = HYST_64;
    endcase
  endfunction

  function automatic logic [7:0] rsp_char(input eltc_rsp_type k, input logic [3:0] idx,
                                          input logic [7:0] v);
    rsp_char = CH_CR;
    if (k != RSP_READ)
    begin
      if (idx == 4'h0)
        rsp_char = (k == RSP_OK) ? CH_ZERO : CH_ONE;
    end
    else
      unique case (idx)
        4'h0:       rsp_char = READ_PREFIX[31:24];
        4'h1:       rsp_char = READ_PREFIX[23:16];
        4'h2:       rsp_char = READ_PREFIX[15:8];
        4'h3:       rsp_char = READ_PREFIX[7:0];
        4'h4, 4'h5: rsp_char = CH_ZERO;
        4'h6:       rsp_char = CH_ZERO + v / 8'd100;
        4'h7:       rsp_char = CH_ZERO + (v / 8'd10) % 8'd10;
        4'h8:       rsp_char = CH_ZERO + v % 8'd10;
        default:    rsp_char = CH_CR;
      endcase
  endfunction

  // ==========================================================
  // Input synchronisers, {frame, B, A}
  logic [2:0] meta_ff, sync_ff, prev_ff;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      meta_ff <= 3'h0;
      sync_ff <= 3'h0;
      prev_ff <= 3'h0;
    end
    else
    begin
      meta_ff <= {i_frame_sync, i_line_sync_b, i_line_sync_a};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // ==========================================================
  // Quadrature decode, hysteresis and trigger generation
  logic [CTRL_W-1:0]       ctrl_ff;
  logic [DIV_W-1:0]        ratio_ff;
  logic signed [POS_W-1:0] nxt_pos;
  logic                    dir_up_ff, nxt_dir_up;
  logic [6:0]              backlash_ff, nxt_backlash;
  logic                    trig_ff, nxt_trig;
  logic                    nxt_scan;
  logic [1:0]              step;
  logic                    a_rise, b_rise, up;

  always_comb
  begin
    a_rise       = sync_ff[0] && !prev_ff[0];
    b_rise       = sync_ff[1] && !prev_ff[1];
    step         = quad_step(prev_ff[1:0], sync_ff[1:0]);
    up           = step == 2'b01;
    nxt_pos      = o_position;
    nxt_dir_up   = dir_up_ff;
    nxt_backlash = backlash_ff;
    nxt_trig     = 1'b0;
    if (!ctrl_ff[ADV_EN_BIT])
      nxt_trig = a_rise;
    else if (step != 2'b00)
    begin
      nxt_pos    = up ? o_position + 16'sd1 : o_position - 16'sd1;
      nxt_dir_up = up;
      if (hyst_span(ctrl_ff[HYST_HI_BIT:HYST_LO_BIT]) != 7'h00 && up != dir_up_ff)
        nxt_backlash = hyst_span(ctrl_ff[HYST_HI_BIT:HYST_LO_BIT]);
      else if (backlash_ff != 7'h00)
        nxt_backlash = backlash_ff - 7'h01;
      else if ((up || ctrl_ff[BIDIR_BIT])
               && (ctrl_ff[FOUR_EDGE_BIT] || nxt_pos[1:0] == 2'b00))
        nxt_trig = 1'b1;
    end
    nxt_scan = i_external_scan_start_mode
               && (ctrl_ff[SCAN_SRC_BIT] ? b_rise : a_rise);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_position            <= '0;
      dir_up_ff             <= 1'b1;
      backlash_ff           <= 7'h00;
      trig_ff               <= 1'b0;
      o_external_scan_start <= 1'b0;
    end
    else
    begin
      o_position            <= nxt_pos;
      dir_up_ff             <= nxt_dir_up;
      backlash_ff           <= nxt_backlash;
      trig_ff               <= nxt_trig;
      o_external_scan_start <= nxt_scan;
    end
  end

  // ==========================================================
  // Divider and line counter
  logic [LCNT_W-1:0] lcnt_ff, nxt_lcnt;

  eltc_divider u_divider (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_trig    (trig_ff),
    .i_ratio   (ratio_ff),
    .o_pulse   (o_line_start)
  );

  always_comb
  begin
    nxt_lcnt = o_line_start ? lcnt_ff + 13'h0001 : lcnt_ff;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      lcnt_ff <= '0;
    else
      lcnt_ff <= nxt_lcnt;
  end

  // ==========================================================
  // Diagnostic pixel substitution
  logic        second_ff, nxt_second;
  logic [15:0] pix;
  logic        buf_ready;

  always_comb
  begin
    pix        = i_pix_data;
    nxt_second = second_ff;
    if (i_pix_valid && buf_ready)
      nxt_second = i_pix_first;
    unique case (ctrl_ff[DIAG_HI_BIT:DIAG_LO_BIT])
      DIAG_OFF: ;
      DIAG_STATES:
        if (i_pix_first)
          pix[7:0] = {sync_ff[2], sync_ff[1], sync_ff[0], 5'h00};
      DIAG_LCNT8:
        if (i_pix_first)
          pix[7:0] = lcnt_ff[7:0];
      DIAG_BOTH:
        if (i_pix_first)
          pix[7:0] = {sync_ff[2], sync_ff[1], sync_ff[0], lcnt_ff[12:8]};
        else if (second_ff)
          pix[7:0] = lcnt_ff[7:0];
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      second_ff <= 1'b0;
    else
      second_ff <= nxt_second;
  end

  eltc_buf2 u_buf (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_data   (pix),
    .i_in_valid  (i_pix_valid),
    .o_in_ready  (buf_ready),
    .o_out_data  (o_pix_data),
    .o_out_valid (o_pix_valid),
    .i_out_ready (i_pix_ready)
  );

  assign o_pix_ready = buf_ready;

  // ==========================================================
  // Command parser and answer sequencer
  typedef enum logic [1:0] {CMD_IDLE, CMD_NUM, CMD_RESP} eltc_cmd_type;

  eltc_cmd_type      st_ff, nxt_st;
  logic [7:0]        op_ff, nxt_op;
  logic [16:0]       val_ff, nxt_val;
  logic              bad_ff, nxt_bad;
  eltc_rsp_type      kind_ff, nxt_kind;
  logic [3:0]        idx_ff, nxt_idx;
  logic [CTRL_W-1:0] nxt_ctrl;
  logic [DIV_W-1:0]  nxt_ratio;
  logic [7:0]        nxt_rsp_byte;
  logic              nxt_rsp_valid;
  logic              take;

  always_comb
  begin
    nxt_st        = st_ff;
    nxt_op        = op_ff;
    nxt_val       = val_ff;
    nxt_bad       = bad_ff;
    nxt_kind      = kind_ff;
    nxt_idx       = idx_ff;
    nxt_ctrl      = ctrl_ff;
    nxt_ratio     = ratio_ff;
    nxt_rsp_valid = o_rsp_valid;
    nxt_rsp_byte  = o_rsp_byte;
    take          = i_cmd_valid && o_cmd_ready;
    unique case (st_ff)
      CMD_IDLE:
        if (take && i_cmd_byte != CH_CR)
        begin
          nxt_op  = i_cmd_byte;
          nxt_val = '0;
          nxt_bad = 1'b0;
          nxt_st  = CMD_NUM;
        end
      CMD_NUM:
        if (take)
        begin
          if (i_cmd_byte >= CH_ZERO && i_cmd_byte <= CH_NINE)
          begin
            if (val_ff > VAL_CAP / 17'd10)
              nxt_bad = 1'b1;
            else
              nxt_val = 17'(val_ff * 17'd10 + 17'(i_cmd_byte - CH_ZERO));
          end
          else if (i_cmd_byte != CH_CR)
            nxt_bad = 1'b1;
          else
          begin
            nxt_kind = RSP_FAIL;
            if (!bad_ff && op_ff == CH_SET_CTRL && val_ff <= CTRL_MAX)
            begin
              nxt_ctrl = val_ff[CTRL_W-1:0];
              nxt_kind = RSP_OK;
            end
            else if (!bad_ff && op_ff == CH_SET_DIV && val_ff != 17'h0
                     && val_ff <= DIV_MAX)
            begin
              nxt_ratio = val_ff[DIV_W-1:0];
              nxt_kind  = RSP_OK;
            end
            else if (!bad_ff && op_ff == CH_INFO && val_ff == INFO_CTRL_IDX)
              nxt_kind = RSP_READ;
            nxt_idx       = 4'h0;
            nxt_rsp_valid = 1'b1;
            nxt_rsp_byte  = rsp_char(nxt_kind, 4'h0, nxt_ctrl);
            nxt_st        = CMD_RESP;
          end
        end
      CMD_RESP:
        if (i_rsp_ready)
        begin
          nxt_idx = idx_ff + 4'h1;
          if (nxt_idx == ((kind_ff == RSP_READ) ? READ_LEN : ACK_LEN))
          begin
            nxt_rsp_valid = 1'b0;
            nxt_st        = CMD_IDLE;
          end
          else
            nxt_rsp_byte = rsp_char(kind_ff, nxt_idx, ctrl_ff);
        end
      default:
        nxt_st = CMD_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      st_ff             <= CMD_IDLE;
      op_ff             <= 8'h00;
      val_ff            <= '0;
      bad_ff            <= 1'b0;
      kind_ff           <= RSP_OK;
      idx_ff            <= 4'h0;
      ctrl_ff           <= CTRL_RESET;
      ratio_ff          <= DIV_RESET;
      o_rsp_valid       <= 1'b0;
      o_rsp_byte        <= 8'h00;
      o_cmd_ready       <= 1'b0;
      o_trigger_control <= CTRL_RESET;
    end
    else
    begin
      st_ff             <= nxt_st;
      op_ff             <= nxt_op;
      val_ff            <= nxt_val;
      bad_ff            <= nxt_bad;
      kind_ff           <= nxt_kind;
      idx_ff            <= nxt_idx;
      ctrl_ff           <= nxt_ctrl;
      ratio_ff          <= nxt_ratio;
      o_rsp_valid       <= nxt_rsp_valid;
      o_rsp_byte        <= nxt_rsp_byte;
      o_cmd_ready       <= nxt_st != CMD_RESP;
      o_trigger_control <= nxt_ctrl;
    end
  end
endmodule // eltc_top
`default_nettype wire

// *** testbench/eltc_chk.sv ***
// Port-level checks of eltc_top, bound to every instance of it.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module eltc_chk
  import eltc_pkg::*;
(
  // Clock and reset
  input wire logic                    i_clk,
  input wire logic                    i_sys_rst,
  // Sync pins
  input wire logic                    i_line_sync_a,
  input wire logic                    i_line_sync_b,
  input wire logic                    i_external_scan_start_mode,
  // Streams
  input wire logic                    o_cmd_ready,
  input wire logic [7:0]              o_rsp_byte,
  input wire logic                    o_rsp_valid,
  input wire logic                    i_rsp_ready,
  input wire logic [15:0]             o_pix_data,
  input wire logic                    o_pix_valid,
  input wire logic                    i_pix_ready,
  // Line timing and state
  input wire logic                    o_line_start,
  input wire logic                    o_external_scan_start,
  input wire logic [CTRL_W-1:0]       o_trigger_control,
  input wire logic signed [POS_W-1:0] o_position
);
  logic       adv;
  logic [1:0] pos_lo;
  assign adv    = o_trigger_control[ADV_EN_BIT];
  assign pos_lo = o_position[1:0];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ==========================================
  // Steps of the trigger path
  sequence s_down_step;
    adv && !o_trigger_control[BIDIR_BIT] && o_position == $past(o_position) - 16'sh0001;
  endsequence
  sequence s_adv_start;
    o_line_start && adv;
  endsequence
  a_scan_from_a: assert property ($rose(i_line_sync_a) && !o_trigger_control[SCAN_SRC_BIT]
    && i_external_scan_start_mode |-> ##[1:4] o_external_scan_start)
    else $error("scan start missing after A rise");
  a_scan_from_b: assert property ($rose(i_line_sync_b) && o_trigger_control[SCAN_SRC_BIT]
    && i_external_scan_start_mode |-> ##[1:4] o_external_scan_start)
    else $error("scan start missing after B rise");
  a_scan_one_cycle: assert property (o_external_scan_start |=> !o_external_scan_start)
    else $error("scan start longer than one cycle");
  a_bypass_still: assert property (!adv [*3] |=> $stable(o_position))
    else $error("position moved in bypass");
  a_pos_unit_step: assert property (o_position != $past(o_position)
    |-> o_position - $past(o_position) inside {16'h0001, 16'hFFFF})
    else $error("position jumped");
  a_down_silent: assert property (s_down_step |=> !o_line_start)
    else $error("down step triggered");
  a_start_moved: assert property (s_adv_start |-> $past(o_position) != $past(o_position, 2))
    else $error("line start without motion");
  a_edge_once: assert property (s_adv_start ##0 !o_trigger_control[FOUR_EDGE_BIT]
    |-> $past(pos_lo) == 2'h0)
    else $error("single-edge trigger off period");
  a_cmd_refused: assert property (o_rsp_valid |-> !o_cmd_ready)
    else $error("command taken during answer");
  a_rsp_hold: assert property (o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp_byte))
    else $error("answer byte dropped");
  a_pix_hold: assert property (o_pix_valid && !i_pix_ready |=> o_pix_valid && $stable(o_pix_data))
    else $error("pixel dropped under stall");
endmodule // eltc_chk
bind eltc_top eltc_chk i_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_line_sync_a(i_line_sync_a),
  .i_line_sync_b(i_line_sync_b), .i_external_scan_start_mode(i_external_scan_start_mode),
  .o_cmd_ready(o_cmd_ready), .o_rsp_byte(o_rsp_byte), .o_rsp_valid(o_rsp_valid),
  .i_rsp_ready(i_rsp_ready), .o_pix_data(o_pix_data), .o_pix_valid(o_pix_valid),
  .i_pix_ready(i_pix_ready), .o_line_start(o_line_start),
  .o_external_scan_start(o_external_scan_start),
  .o_trigger_control(o_trigger_control), .o_position(o_position)
);
`default_nettype wire

// *** testbench/eltc_enc_model.sv ***
// Quadrature encoder and frame sync source on the sync pins.
// Assumes the bench calls its tasks just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module eltc_enc_model (
  // Sync pins
  output var logic o_line_sync_a,
  output var logic o_line_sync_b,
  output var logic o_frame_sync
);
  logic [1:0] phase = 2'h0;
  initial o_frame_sync = 1'b0;
  // ==========================================
  // Up order of B and A: 00, 01, 11, 10
  always_comb o_line_sync_a = phase[1] ^ phase[0];
  always_comb o_line_sync_b = phase[1];
  // One step; the caller sets the pace
  task automatic step(input logic up);
    phase = up ? phase + 2'h1 : phase - 2'h1;
  endtask
  task automatic frame(input logic v);
    o_frame_sync = v;
  endtask
endmodule // eltc_enc_model
`default_nettype wire

// *** testbench/test_encoder_line_trigger_control.sv ***
// Self-checking bench of the encoder line trigger control top.
// Assumes the encoder model on the sync pins and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module test_encoder_line_trigger_control
  import eltc_pkg::*;
;
  // ==========================================
  // Signals and tables
  logic               i_clk       = 1'b0;
  logic               i_sys_rst   = 1'b1;
  logic [7:0]         i_cmd_byte  = 8'h00;
  logic               i_cmd_valid = 1'b0;
  logic               i_rsp_ready = 1'b0;
  logic [15:0]        i_pix_data  = 16'h0000;
  logic               i_pix_first = 1'b0;
  logic               i_pix_valid = 1'b0;
  logic               i_pix_ready = 1'b0;
  logic               stall       = 1'b0;
  logic               i_scan_mode = 1'b1;
  wire                sync_a, sync_b, sync_f;
  logic               o_cmd_ready, o_rsp_valid, o_pix_ready, o_pix_valid;
  logic               o_line_start, o_external_scan_start;
  logic [7:0]         o_rsp_byte, o_trigger_control;
  logic [15:0]        o_pix_data;
  logic signed [15:0] o_position;
  logic [7:0]         rsp_q [$];
  logic [15:0]        pix_q [$];
  int                 errors, comparisons, cycles, starts, scans, a_rises, b_rises;
  int                 exp_pos, exp_lcnt;
  string cq [9] = '{"I29", "Y256", "Y25A", "Q7", "V0", "V32768", "V32767", "Y232", "I29"};
  string aq [9] = '{"SyC:00000", "1", "1", "1", "1", "1", "0", "0", "SyC:00232"};
  logic [7:0] tc [10] = '{8'hE0, 8'hA0, 8'h80, 8'hC0, 8'hE8, 8'hF0, 8'hF8, 8'hE0, 8'h78, 8'h7C};
  int tr [10] = '{1, 1, 1, 1, 1, 1, 1, 3, 1, 1};
  int tu [10] = '{8, 8, 8, 8, 6, 20, 70, 12, 8, 8};
  int td [10] = '{4, 4, 0, 8, 10, 20, 66, 0, 8, 8};
  int ts [10] = '{12, 8, 2, 4, 6, 6, 6, 4, 4, 4};
  eltc_enc_model i_enc (
    .o_line_sync_a(sync_a), .o_line_sync_b(sync_b), .o_frame_sync(sync_f)
  );
  eltc_top i_dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_line_sync_a(sync_a),
    .i_line_sync_b(sync_b), .i_frame_sync(sync_f), .i_external_scan_start_mode(i_scan_mode),
    .i_cmd_byte(i_cmd_byte), .i_cmd_valid(i_cmd_valid), .o_cmd_ready(o_cmd_ready),
    .o_rsp_byte(o_rsp_byte), .o_rsp_valid(o_rsp_valid), .i_rsp_ready(i_rsp_ready),
    .i_pix_data(i_pix_data), .i_pix_first(i_pix_first), .i_pix_valid(i_pix_valid),
    .o_pix_ready(o_pix_ready), .o_pix_data(o_pix_data), .o_pix_valid(o_pix_valid),
    .i_pix_ready(i_pix_ready), .o_line_start(o_line_start),
    .o_external_scan_start(o_external_scan_start),
    .o_trigger_control(o_trigger_control), .o_position(o_position)
  );
  always #5 i_clk = ~i_clk;
  always @(posedge sync_a) a_rises++;
  always @(posedge sync_b) b_rises++;
  // ==========================================
  // Random far-side stalls and output watch
  always @(posedge i_clk)
  begin
    #1;
    i_rsp_ready = $urandom_range(3) != 0;
    i_pix_ready = !stall && ($urandom_range(3) != 0);
  end
  always @(posedge i_clk)
  begin
    if (o_rsp_valid === 1'b1 && i_rsp_ready === 1'b1) `CHK(o_rsp_byte, rsp_q.pop_front())
    if (o_pix_valid === 1'b1 && i_pix_ready === 1'b1) `CHK(o_pix_data, pix_q.pop_front())
    if (o_line_start === 1'b1) starts++;
    if (o_external_scan_start === 1'b1) scans++;
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      final_report();
    end
  end
  task automatic final_report();
    if (errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic put(input logic [7:0] b);
    i_cmd_byte = b;
    i_cmd_valid = 1'b1;
    do @(posedge i_clk); while (o_cmd_ready !== 1'b1);
    #1;
  endtask
  task automatic cmd(input string s, input string r);
    for (int i = 0; i < r.len(); i++) rsp_q.push_back(r[i]);
    rsp_q.push_back(CH_CR);
    for (int i = 0; i < s.len(); i++) put(s[i]);
    put(CH_CR);
    i_cmd_valid = 1'b0;
    for (int i = 0; i < 300 && rsp_q.size() > 0; i++) @(posedge i_clk);
    #1;
  endtask
  task automatic pix(input logic [15:0] d, input logic f, input logic [15:0] e);
    pix_q.push_back(e);
    i_pix_data = d;
    i_pix_first = f;
    i_pix_valid = 1'b1;
    do @(posedge i_clk); while (o_pix_ready !== 1'b1);
    #1;
  endtask
  task automatic mv(input int n, input logic up);
    repeat (n)
    begin
      i_enc.step(up);
      repeat (2 + $urandom_range(5)) @(posedge i_clk);
      #1;
    end
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    logic [15:0] d [3];
    logic [15:0] e0;
    logic [7:0]  st;
    int          s0, x0, a0, b0;
    void'($urandom(32'h5B60712E));
    repeat (12) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    `CHK(o_trigger_control, CTRL_RESET)
    foreach (cq[i]) cmd(cq[i], aq[i]);
    `CHK(o_trigger_control, 8'hE8)
    foreach (tc[i])
    begin
      cmd($sformatf("Y%0d", tc[i]), "0");
      cmd($sformatf("V%0d", tr[i]), "0");
      s0 = starts;
      x0 = scans;
      a0 = a_rises;
      b0 = b_rises;
      i_scan_mode = i != 3;
      mv(tu[i], 1'b1);
      mv(td[i], 1'b0);
      repeat (12) @(posedge i_clk);
      #1;
      if (tc[i][7]) exp_pos += tu[i] - td[i];
      exp_lcnt += ts[i];
      `CHK(starts - s0, ts[i])
      `CHK(scans - x0, !i_scan_mode ? 0 : tc[i][2] ? b_rises - b0 : a_rises - a0)
      `CHK(o_position, exp_pos[15:0])
    end
    for (int m = 0; m < 4; m++)
    begin
      cmd($sformatf("Y%0d", m), "0");
      i_enc.frame(1'($urandom_range(1)));
      stall = 1'b1;
      repeat (4) @(posedge i_clk);
      #1;
      st = {sync_f, sync_b, sync_a, exp_lcnt[12:8]};
      for (int k = 0; k < 3; k++) d[k] = 16'($urandom);
      e0 = m == 0 ? d[0] : {d[0][15:8], m == 2 ? exp_lcnt[7:0] : m == 1 ? {st[7:5], 5'h00} : st};
      pix(d[0], 1'b1, e0);
      pix(d[1], 1'b0, m == 3 ? {d[1][15:8], exp_lcnt[7:0]} : d[1]);
      i_pix_valid = 1'b0;
      `CHK(o_pix_ready, 1'b0)
      stall = 1'b0;
      @(posedge i_clk);
      #1;
      pix(d[2], 1'b0, d[2]);
      i_pix_valid = 1'b0;
    end
    repeat (20) @(posedge i_clk);
    #1;
    `CHK(pix_q.size() + rsp_q.size(), 0)
    final_report();
  end
endmodule // test_encoder_line_trigger_control
`default_nettype wire
